// [pkg/hsb_pkg.sv]
/*
  Shared constants and carrier types for the hot-swap two-wire bus connector.
  Assumes a single 50 MHz system clock; all pin levels are open-drain and are
  resolved by the bench from the output enables.
*/
package hsb_pkg;

  // System clock period
  localparam int CLK_NS = 20;

  // Initialisation time before the idle/stop detector is armed
  localparam int INIT_TIME_NS = 1000;
  localparam int INIT_CYC = (INIT_TIME_NS + CLK_NS - 1) / CLK_NS;

  // Local timebase tick used for idle measurement
  localparam int TICK_TIME_NS = 1000;
  localparam int TICK_CYC = (TICK_TIME_NS + CLK_NS - 1) / CLK_NS;

  // Default idle time in timebase ticks (microseconds)
  localparam int IDLE_TICKS_DEF = 50;

  // Rise-time accelerator on-time after a qualified rising edge
  localparam int ACCEL_TIME_NS = 100;
  localparam int ACCEL_CYC = ACCEL_TIME_NS / CLK_NS;

  // Synchroniser input bit positions
  localparam int SYNC_W = 6;
  localparam int SYNC_EN_BIT = 4;
  localparam int SYNC_PG_BIT = 5;

  // Line index within the four-line vector
  localparam int LN_BP_DATA = 0;
  localparam int LN_BP_CLOCK = 1;
  localparam int LN_CARD_DATA = 2;
  localparam int LN_CARD_CLOCK = 3;

  // One bit per bus line, backplane and card
  typedef struct packed {
    logic card_clock_pin;
    logic card_data_pin;
    logic backplane_clock_pin;
    logic backplane_data_pin;
  } hsb_lines_t;

  // Connection state
  typedef enum logic [1:0] {
    HSB_OFF,
    HSB_INIT,
    HSB_ARMED,
    HSB_CONN
  } hsb_state_t;

endpackage

// [verilog/hsb_sync.sv]
/*
  Two flip-flop synchroniser, one per bit, for levels arriving from outside
  the MCLK domain. Assumes synchronous active-low reset.
*/
`timescale 1ns/1ns
module hsb_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // Per-bit two stage capture; first stage feeds only the second
  // Reset clears both stages so enable and power read as off until really sampled
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++)
    begin : g_bit
      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          meta_q[gi] <= 1'b0;
          q[gi] <= 1'b0;
        end
        else
        begin
          meta_q[gi] <= d[gi];
          q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

endmodule // hsb_sync

// [verilog/hsb_connector.sv]
/*
  Connect control and bidirectional low propagation for a hot-swap two-wire
  bus connector joining a backplane segment to a card segment.
  Assumes open-drain lines with external pull-ups, all inputs asynchronous
  to MCLK, and an analog front end that obeys PRECHARGE_ON and ACCEL_ON.
*/
// Overview of operation
// - Enable low: low current, accelerators off, sides isolated.
// - Ready pulled low while disconnected, released once connected.
// - Power not good: disconnected, every line undriven.
// - Power-up with enable high, or enable rising: initialise with precharge on.
// - Idle/stop detector armed only after initialisation ends.
// - Connect when all lines idle long enough or stop seen with all high.
// - Precharge on from initialisation until the connection is made.
// - When connected, a low on one side is driven onto the other.
// - Only a low that persists past the filter counts as falling.
// - Both sides stay low until the originating driver releases.
// - Released rising line turns its accelerator on, pull-down off.
// - Ready high only when enabled and start-up complete.
// - Enable returning high waits for idle or stop before reconnecting.
`timescale 1ns/1ns
module hsb_connector #(
  parameter int IDLE_TICKS = hsb_pkg::IDLE_TICKS_DEF
) (
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic ENABLE,
  input wire logic POWER_GOOD,
  input wire hsb_pkg::hsb_lines_t BUS_I,
  output hsb_pkg::hsb_lines_t BUS_O,
  output hsb_pkg::hsb_lines_t BUS_OE,
  output hsb_pkg::hsb_lines_t ACCEL_ON,
  output logic PRECHARGE_ON,
  output logic LOW_POWER,
  output logic READY_O,
  output logic READY_OE
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation

  logic [hsb_pkg::SYNC_W-1:0] sync_d;
  logic [hsb_pkg::SYNC_W-1:0] sync_q;
  logic [3:0] line_s;
  logic en_s;
  logic pg_s;

  assign sync_d = {POWER_GOOD, ENABLE, BUS_I};

  hsb_sync #(.W(hsb_pkg::SYNC_W)) u_sync (
    .clk(MCLK),
    .rst_n(NRST),
    .d(sync_d),
    .q(sync_q)
  );

  assign line_s = sync_q[3:0];
  assign en_s = sync_q[hsb_pkg::SYNC_EN_BIT];
  assign pg_s = sync_q[hsb_pkg::SYNC_PG_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Line history and falling-edge qualification

  logic [3:0] line_prev_q;
  logic [3:0] low_f;
  logic all_high;

  // Previous synchronised level of every line
  always_ff @(posedge MCLK)
  begin
    if (!NRST)
      line_prev_q <= 4'hf;
    else
      line_prev_q <= line_s;
  end

  // Low counts only after two consecutive low samples
  assign low_f = ~line_s & ~line_prev_q;
  assign all_high = &line_s;

  ////////////////////////////////////////////////////////////////////////////
  // Start-up state machine

  hsb_pkg::hsb_state_t st_q;
  logic [$clog2(hsb_pkg::INIT_CYC+1)-1:0] init_cnt_q;
  logic idle_done;
  logic stop_seen;
  logic init_last;

  assign init_last = (init_cnt_q == ($bits(init_cnt_q))'(hsb_pkg::INIT_CYC - 1));

  // Power and enable gate every state; enable low always drops to off
  always_ff @(posedge MCLK)
  begin
    if (!NRST)
      st_q <= hsb_pkg::HSB_OFF;
    else if (!pg_s || !en_s)
      st_q <= hsb_pkg::HSB_OFF;
    else
    begin
      case (st_q)
        hsb_pkg::HSB_OFF: st_q <= hsb_pkg::HSB_INIT;
        hsb_pkg::HSB_INIT:
          if (init_last)
            st_q <= hsb_pkg::HSB_ARMED;
        hsb_pkg::HSB_ARMED:
          if (all_high && (idle_done || stop_seen))
            st_q <= hsb_pkg::HSB_CONN;
        hsb_pkg::HSB_CONN: st_q <= hsb_pkg::HSB_CONN;
        default: st_q <= hsb_pkg::HSB_OFF;
      endcase
    end
  end

  // Initialisation timer
  always_ff @(posedge MCLK)
  begin
    if (!NRST)
      init_cnt_q <= '0;
    else if (st_q != hsb_pkg::HSB_INIT)
      init_cnt_q <= '0;
    else if (!init_last)
      init_cnt_q <= init_cnt_q + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Idle timebase and stop detection

  logic [$clog2(hsb_pkg::TICK_CYC+1)-1:0] tick_cnt_q;
  logic tick;
  logic [15:0] idle_cnt_q;

  assign tick = (tick_cnt_q == ($bits(tick_cnt_q))'(hsb_pkg::TICK_CYC - 1));

  // Free running divider giving one-cycle tick pulses
  always_ff @(posedge MCLK)
  begin
    if (!NRST || tick)
      tick_cnt_q <= '0;
    else
      tick_cnt_q <= tick_cnt_q + 1'b1;
  end

  // Idle counter restarts on any low line or while not armed
  always_ff @(posedge MCLK)
  begin
    if (!NRST || st_q != hsb_pkg::HSB_ARMED || !all_high)
      idle_cnt_q <= '0;
    else if (tick && !idle_done)
      idle_cnt_q <= idle_cnt_q + 1'b1;
  end

  assign idle_done = (idle_cnt_q >= 16'(IDLE_TICKS));

  // Stop: backplane data rises while backplane clock stays high
  assign stop_seen = (st_q == hsb_pkg::HSB_ARMED)
    && line_s[hsb_pkg::LN_BP_CLOCK] && line_prev_q[hsb_pkg::LN_BP_CLOCK]
    && line_s[hsb_pkg::LN_BP_DATA] && !line_prev_q[hsb_pkg::LN_BP_DATA];

  ////////////////////////////////////////////////////////////////////////////
  // Bidirectional low propagation and accelerators

  logic conn;
  logic [3:0] drv_q;
  logic [3:0] own_q;
  logic [3:0] accel_q;
  logic [2:0] acc_cnt_q [4];

  assign conn = (st_q == hsb_pkg::HSB_CONN) && en_s && pg_s;

  genvar gl;
  generate
    for (gl = 0; gl < 4; gl++)
    begin : g_line
      localparam int PEER = gl ^ 2;

      // Drive this line low while the peer is held low by someone else
      always_ff @(posedge MCLK)
      begin
        if (!NRST || !conn)
          drv_q[gl] <= 1'b0;
        else
          drv_q[gl] <= low_f[PEER] && !own_q[PEER];
      end

      // Our own low is masked until the line is seen high again
      always_ff @(posedge MCLK)
      begin
        if (!NRST || !conn)
          own_q[gl] <= 1'b0;
        else if (drv_q[gl])
          own_q[gl] <= 1'b1;
        else if (line_s[gl])
          own_q[gl] <= 1'b0;
      end

      // Accelerator timer on a released line rising
      always_ff @(posedge MCLK)
      begin
        if (!NRST || !conn)
          acc_cnt_q[gl] <= 3'h0;
        else if (line_s[gl] && !line_prev_q[gl] && !drv_q[gl])
          acc_cnt_q[gl] <= 3'(hsb_pkg::ACCEL_CYC);
        else if (acc_cnt_q[gl] != 3'h0)
          acc_cnt_q[gl] <= acc_cnt_q[gl] - 3'h1;
      end

      assign accel_q[gl] = (acc_cnt_q[gl] != 3'h0);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  logic precharge_q;
  logic low_power_q;
  logic ready_q;

  // Registered status outputs
  always_ff @(posedge MCLK)
  begin
    if (!NRST)
    begin
      precharge_q <= 1'b0;
      low_power_q <= 1'b1;
      ready_q <= 1'b0;
    end
    else
    begin
      precharge_q <= pg_s && en_s && (st_q == hsb_pkg::HSB_INIT
        || st_q == hsb_pkg::HSB_ARMED);
      low_power_q <= !en_s;
      ready_q <= conn;
    end
  end

  assign BUS_O = '0;
  assign BUS_OE = drv_q;
  assign ACCEL_ON = accel_q;
  assign PRECHARGE_ON = precharge_q;
  assign LOW_POWER = low_power_q;
  assign READY_O = 1'b0;
  assign READY_OE = !ready_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);

  sequence s_enabled_init;
    st_q == hsb_pkg::HSB_INIT ##1 st_q == hsb_pkg::HSB_INIT;
  endsequence

  sequence s_init_done;
    st_q == hsb_pkg::HSB_INIT && init_last && pg_s && en_s;
  endsequence

  a_disabled_isolated: assert property (!en_s |=> BUS_OE == '0 && ACCEL_ON == '0)
    else $error("lines driven while disabled");
  a_ready_tracks_conn: assert property (READY_OE == !$past(conn))
    else $error("ready does not follow connection");
  a_power_off_quiet: assert property (!pg_s |=> BUS_OE == '0 ##1 !PRECHARGE_ON)
    else $error("lines active without power");
  a_start_init: assert property (
    st_q == hsb_pkg::HSB_OFF && pg_s && en_s |=> st_q == hsb_pkg::HSB_INIT)
    else $error("no initialisation on enable");
  a_init_length: assert property (s_init_done |=> st_q == hsb_pkg::HSB_ARMED)
    else $error("initialisation end missed");
  a_no_early_conn: assert property (
    st_q == hsb_pkg::HSB_ARMED && !all_high |=> st_q != hsb_pkg::HSB_CONN)
    else $error("connected with a low line");
  a_precharge_window: assert property (
    s_enabled_init |=> PRECHARGE_ON || !en_s || !pg_s)
    else $error("precharge off during init");
  a_precharge_off_conn: assert property (
    st_q == hsb_pkg::HSB_CONN ##1 st_q == hsb_pkg::HSB_CONN |=> !PRECHARGE_ON)
    else $error("precharge on while connected");
  a_low_propagates: assert property (
    conn ##1 conn && low_f[0] && !own_q[0] && conn |=> BUS_OE[2] || !conn)
    else $error("backplane data low not propagated");
  // One-sample low on the card data line
  sequence s_card_glitch;
    line_s[hsb_pkg::LN_CARD_DATA] ##1 !line_s[hsb_pkg::LN_CARD_DATA]
      ##1 line_s[hsb_pkg::LN_CARD_DATA];
  endsequence

  a_glitch_ignored: assert property (s_card_glitch |-> !BUS_OE[0])
    else $error("short glitch propagated");
  a_idle_restart: assert property (
    st_q == hsb_pkg::HSB_ARMED && !all_high |=> idle_cnt_q == 16'h0)
    else $error("idle count not restarted");
  a_accel_pulse: assert property (
    conn && $rose(accel_q[1]) |-> accel_q[1] [*5] ##1 !accel_q[1] || !conn)
    else $error("accelerator pulse length wrong");

endmodule // hsb_connector

// [test/hsb_bus_peer.sv]
/*
  Backplane and card bus parties: external open-drain drivers and pull-ups.
  Assumes the bench calls its tasks; lines resolve from all pull-downs.
*/
`timescale 1ns/1ns
module hsb_bus_peer (
  input wire hsb_pkg::hsb_lines_t dev_oe,
  output hsb_pkg::hsb_lines_t lines
);
  logic [3:0] ext_q = 4'h0;
  // Wired-AND with pull-ups: a released line goes high
  assign lines = hsb_pkg::hsb_lines_t'(~(4'(dev_oe) | ext_q));
  // Hold one line low or let it go
  task automatic pull(input int ln, input logic lo);
    ext_q[ln] = lo;
  endtask
  // Backplane transfer at a 160 ns link period; stretch slows the answer
  task automatic frame(input logic [31:0] bits, input int n, input int stretch);
    pull(0, 1'b1);
    #80;
    for (int i = 0; i < n; i++)
    begin
      pull(1, 1'b1);
      pull(0, ~bits[i]);
      #(80 + stretch);
      pull(1, 1'b0);
      #80;
    end
    pull(1, 1'b1);
    pull(0, 1'b1);
    #80;
    pull(1, 1'b0);
    #80;
    pull(0, 1'b0);
  endtask
endmodule // hsb_bus_peer

// [test/hsb_connector_test.sv]
/*
  Self-checking bench for the bus connector with an integer reference model.
  Assumes the design package and the bus peer model are compiled first.
*/
`timescale 1ns/1ns
`define CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin bad_count++; \
  $display("MISMATCH %s expected %0h seen %0h", what, exp, got); end end
module hsb_connector_test;
  localparam int IDLE = 3;
  localparam int IDLE_C = IDLE * hsb_pkg::TICK_CYC;
  logic MCLK = 1'b0;
  logic NRST = 1'b0;
  logic ENABLE = 1'b1;
  logic POWER_GOOD = 1'b0;
  hsb_pkg::hsb_lines_t BUS_I, BUS_O, BUS_OE, ACCEL_ON;
  logic PRECHARGE_ON, LOW_POWER, READY_O, READY_OE;
  logic [10:0] obs;
  int bad_count = 0;
  int cmp_count = 0;
  int t, n, ln, conn_m;
  logic done;
  hsb_connector #(.IDLE_TICKS(IDLE)) u_dut (.MCLK(MCLK), .NRST(NRST), .ENABLE(ENABLE),
    .POWER_GOOD(POWER_GOOD), .BUS_I(BUS_I), .BUS_O(BUS_O), .BUS_OE(BUS_OE),
    .ACCEL_ON(ACCEL_ON), .PRECHARGE_ON(PRECHARGE_ON), .LOW_POWER(LOW_POWER),
    .READY_O(READY_O), .READY_OE(READY_OE));
  hsb_bus_peer u_peer (.dev_oe(BUS_OE), .lines(BUS_I));
  // Outputs gathered for bit-indexed waits
  assign obs = {READY_OE, PRECHARGE_ON, LOW_POWER, ACCEL_ON, BUS_OE};
  // 50 MHz clock
  initial
  begin
    forever #10 MCLK = ~MCLK;
  end
  ////////////////////////////////////////////////////////////////
  // Wait at falling edges until an output bit takes a value
  task automatic wait_bit(input int b, input logic v, input int lim, output int c);
    c = 0;
    while (obs[b] !== v && c <= lim)
    begin
      @(negedge MCLK);
      c++;
    end
  endtask
  // Hold a line low for some cycles; the peer must follow only while connected
  task automatic hold_low(input int i, input int cyc);
    u_peer.pull(i, 1'b1);
    wait_bit(i ^ 2, conn_m[0], 6, t);
    `CHK("peer pull-down", 1'b1, t <= 6)
    `CHK("own pull-down", 1'b0, obs[i])
    repeat (cyc) @(negedge MCLK);
    `CHK("peer held", conn_m[0], obs[i ^ 2])
    u_peer.pull(i, 1'b0);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge MCLK);
    bad_count++;
    conclude();
  end
  ////////////////////////////////////////////////////////////////
  // Test sequence
  initial
  begin
    conn_m = 0;
    void'($urandom(81));
    repeat (4) @(negedge MCLK);
    NRST = 1'b1;
    repeat (3) @(negedge MCLK);
    u_peer.pull(0, 1'b1);
    repeat (8) @(negedge MCLK);
    `CHK("oe unpowered", 4'h0, 4'(BUS_OE))
    `CHK("ready unpowered", 1'b1, READY_OE)
    `CHK("precharge unpowered", 1'b0, PRECHARGE_ON)
    `CHK("bus out", 4'h0, 4'(BUS_O))
    `CHK("ready out", 1'b0, READY_O)
    u_peer.pull(0, 1'b0);
    $display("test unpowered done");
    POWER_GOOD = 1'b1;
    wait_bit(9, 1'b1, 8, t);
    `CHK("precharge on", 1'b1, t <= 8)
    repeat (hsb_pkg::INIT_CYC) @(negedge MCLK);
    `CHK("ready in init", 1'b1, READY_OE)
    wait_bit(10, 1'b0, IDLE_C + 10, t);
    `CHK("idle connect late", 1'b1, t <= IDLE_C + 10)
    `CHK("idle connect early", 1'b1, t >= IDLE_C - hsb_pkg::TICK_CYC - 8)
    conn_m = 1;
    wait_bit(9, 1'b0, 2, t);
    `CHK("precharge off", 1'b1, t <= 2)
    `CHK("low power off", 1'b0, LOW_POWER)
    $display("test power-up done");
    for (int i = 0; i < 4; i++)
    begin
      hold_low(i, 3 + $urandom % 20);
      wait_bit(i ^ 2, 1'b0, 6, t);
      `CHK("peer release", 1'b1, t <= 6)
      wait_bit(4 + (i ^ 2), 1'b1, 8, t);
      n = 0;
      while (obs[4 + (i ^ 2)] === 1'b1 && n < 20)
      begin
        @(negedge MCLK);
        n++;
      end
      `CHK("accel length", hsb_pkg::ACCEL_CYC, n)
      repeat (10) @(negedge MCLK);
    end
    $display("test propagate done");
    // One-cycle low on every line, starting at a random one
    ln = $urandom % 4;
    for (int i = 0; i < 4; i++)
    begin
      u_peer.pull((ln + i) % 4, 1'b1);
      @(negedge MCLK);
      u_peer.pull((ln + i) % 4, 1'b0);
      repeat (8) @(negedge MCLK);
      `CHK("glitch ignored", 4'h0, 4'(BUS_OE))
    end
    $display("test glitch done");
    ENABLE = 1'b0;
    conn_m = 0;
    wait_bit(8, 1'b1, 6, t);
    `CHK("low power", 1'b1, t <= 6)
    `CHK("ready disabled", 1'b1, READY_OE)
    `CHK("accel disabled", 4'h0, 4'(ACCEL_ON))
    hold_low(1, 8);
    `CHK("isolated", 4'h0, 4'(BUS_OE))
    $display("test disable done");
    done = 1'b0;
    fork
      begin
        u_peer.frame($urandom, 27, 20 * ($urandom % 3));
        done = 1'b1;
      end
    join_none
    ENABLE = 1'b1;
    n = 0;
    while (done !== 1'b1)
    begin
      @(negedge MCLK);
      n = n | (READY_OE !== 1'b1);
    end
    `CHK("no connect mid-traffic", 0, n)
    wait_bit(10, 1'b0, 40, t);
    `CHK("stop connect", 1'b1, t <= 40)
    `CHK("stop precharge off", 1'b0, PRECHARGE_ON)
    conn_m = 1;
    hold_low(3, 5);
    $display("test stop connect done");
    repeat (10) @(negedge MCLK);
    POWER_GOOD = 1'b0;
    conn_m = 0;
    wait_bit(10, 1'b1, 6, t);
    `CHK("power loss ready", 1'b1, t <= 6)
    `CHK("power loss oe", 4'h0, 4'(BUS_OE))
    $display("test power loss done");
    conclude();
  end
endmodule // hsb_connector_test
